// File: logic/rtc_pkg.sv
// RTC constants: register offsets, field positions, reset values
// Assumes a byte-addressed register port with 8-bit address
// Overview of operation
// RULE1: Sixteen 32-bit backup words hold 64 bytes of application data.
// RULE2: Backup words survive system reset, power reset and standby exit.
// RULE3: Calendar keeps subsecond to year in BCD with 12 or 24 hour format; the code keeps the subsecond as a binary down-counter.
// RULE4: Date rollover follows month lengths of 28, 29 in leap years, 30, 31.
// RULE5: With reference detection on, a 50 or 60 Hz input paces the seconds.
// RULE6: Two programmable alarms each raise a wakeup-capable event on match.
// RULE7: A shift of 1 to 32767 clock pulses retards time, with optional +1 s.
// RULE8: Smooth calibration drops or adds pulses at about 1 ppm steps.
// RULE9: Three tamper inputs pass a programmable filter and raise events.
// RULE10: Timestamp pin or tamper event captures the calendar.
// RULE11: A 17-bit auto-reload wakeup counter raises a periodic event.
// RULE12: Clock source is crystal, oscillator, internal RC or fast clock/32.
// RULE13: Each event sets a status flag with its own interrupt enable.
package rtc_pkg;
	localparam logic [7:0] OFS_TIME = 8'h00;
	localparam logic [7:0] OFS_DATE = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_SUBSEC = 8'h0c;
	localparam logic [7:0] OFS_PRESC = 8'h10;
	localparam logic [7:0] OFS_WUT = 8'h14;
	localparam logic [7:0] OFS_CALIB = 8'h18;
	localparam logic [7:0] OFS_SHIFT = 8'h1c;
	localparam logic [7:0] OFS_ALRA = 8'h20;
	localparam logic [7:0] OFS_ALRB = 8'h24;
	localparam logic [7:0] OFS_TSTIME = 8'h28;
	localparam logic [7:0] OFS_TSDATE = 8'h2c;
	localparam logic [7:0] OFS_TSSS = 8'h30;
	localparam logic [7:0] OFS_ISTS = 8'h34;
	localparam logic [7:0] OFS_ICLR = 8'h38;
	localparam logic [7:0] OFS_IEN = 8'h3c;
	localparam logic [7:0] OFS_BKP = 8'h40;
	localparam int NUM_BKP = 16;
	localparam int NUM_TAMP = 3;
	localparam int CTRL_W = 9;
	localparam int C_FMT12 = 0;
	localparam int C_REFON = 1;
	localparam int C_REF60 = 2;
	localparam int C_WUTEN = 3;
	localparam int C_TAMPTS = 4;
	localparam int C_SEL = 5;
	localparam int C_FILT = 7;
	localparam int STS_W = 7;
	localparam int S_ALRA = 0;
	localparam int S_ALRB = 1;
	localparam int S_WUT = 2;
	localparam int S_TS = 3;
	localparam int S_TAMP = 4;
	localparam int SH_ADD1S = 31;
	localparam int CAL_PLUS = 15;
	localparam int CALP_BITS = 11;
	localparam int HDIV_MSB = 4;
	localparam int AL_MSK_SEC = 7;
	localparam int AL_MSK_MIN = 15;
	localparam int AL_MSK_HR = 23;
	localparam int AL_MSK_DT = 31;
	localparam logic [14:0] PRESC_RST = 15'h7fff;
	localparam logic [16:0] WUT_RST = 17'h1ffff;
	localparam logic [5:0] REF50_LAST = 6'h31;
	localparam logic [5:0] REF60_LAST = 6'h3b;
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam logic [6:0] SEC_LAST = 7'h59;
	localparam logic [6:0] MIN_LAST = 7'h59;
	localparam logic [5:0] HR_ONE = 6'h01;
	localparam logic [5:0] HR_ELEVEN = 6'h11;
	localparam logic [5:0] HR_TWELVE = 6'h12;
	localparam logic [5:0] HR_LAST24 = 6'h23;
	localparam logic [2:0] WD_FIRST = 3'h1;
	localparam logic [2:0] WD_LAST = 3'h7;
	localparam logic [2:0] WD_RST = 3'h6;
	localparam logic [5:0] DAY_ONE = 6'h01;
	localparam logic [5:0] DAY_28 = 6'h28;
	localparam logic [5:0] DAY_29 = 6'h29;
	localparam logic [5:0] DAY_30 = 6'h30;
	localparam logic [5:0] DAY_31 = 6'h31;
	localparam logic [4:0] MON_JAN = 5'h01;
	localparam logic [4:0] MON_FEB = 5'h02;
	localparam logic [4:0] MON_APR = 5'h04;
	localparam logic [4:0] MON_JUN = 5'h06;
	localparam logic [4:0] MON_SEP = 5'h09;
	localparam logic [4:0] MON_NOV = 5'h11;
	localparam logic [4:0] MON_DEC = 5'h12;
	localparam logic [7:0] YR_LAST = 8'h99;
	typedef enum logic [1:0] {
		SRC_XTAL = 2'b00,
		SRC_OSC = 2'b01,
		SRC_LSI = 2'b10,
		SRC_FAST32 = 2'b11
	} rtc_src_t;
endpackage

// File: logic/rtc_top.sv
// RTC core: BCD calendar, alarms, wakeup timer, tamper, timestamp, backup
// Assumes every input is synchronous to mclk; source clocks arrive as levels
`timescale 1ns/100ps
`default_nettype none
module rtc_top
	import rtc_pkg::*;
(
	// System
	input wire logic mclk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Clock sources
	input wire logic clk_xtal,
	input wire logic clk_osc,
	input wire logic clk_lsi,
	input wire logic high_speed_external_clock,
	input wire logic ref_clk_in,
	// Event pins
	input wire logic tamper_input_one,
	input wire logic tamper_input_two,
	input wire logic tamper_input_three,
	input wire logic timestamp_input,
	// Interrupt and wakeup request
	output logic irq
);
	typedef struct packed {
		logic [NUM_BKP-1:0][31:0] bkp;
		logic pm;
		logic [5:0] hr;
		logic [6:0] mn;
		logic [6:0] sc;
		logic [7:0] yr;
		logic [2:0] wd;
		logic [4:0] mo;
		logic [5:0] dt;
		logic [14:0] ss;
		logic [14:0] presc;
		logic [14:0] shcnt;
		logic [16:0] wut;
		logic [16:0] wucnt;
		logic [8:0] calm;
		logic calp;
		logic [19:0] win;
		logic [CTRL_W-1:0] ctrl;
		logic [31:0] alra;
		logic [31:0] alrb;
		logic [31:0] tst;
		logic [31:0] tsd;
		logic [14:0] tss;
		logic [STS_W-1:0] sts;
		logic [STS_W-1:0] ien;
		logic [4:0] hdiv;
		logic fast_p;
		logic src_p;
		logic ref_p;
		logic [5:0] refcnt;
		logic ts_p;
		logic [NUM_TAMP-1:0][3:0] tcnt;
		logic [31:0] rdata;
		logic irq;
	} rtc_state_t;
	rtc_state_t s_reg;
	rtc_state_t s_next;
	logic lvl, tick, cal_tick, extra, pre_sec, ref_sec, add1s, sec_step, day_roll, ts_edge;
	logic [1:0] dec;
	logic [3:0] need;
	logic [NUM_TAMP-1:0] tin, tev;
	logic [STS_W-1:0] ev, clr;
	logic [31:0] rmux;
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == BCD_NINE) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h1;
	endfunction
	function automatic logic [5:0] month_last(input logic [4:0] mo, input logic [7:0] yr);
		logic [1:0] y4;
		// Year mod 4 from BCD digits: 10t+u = 2t+u mod 4
		y4 = yr[1:0] + {yr[4], 1'b0};
		case (mo)
			MON_FEB: month_last = (y4 == 2'b00) ? DAY_29 : DAY_28;
			MON_APR, MON_JUN, MON_SEP, MON_NOV: month_last = DAY_30;
			default: month_last = DAY_31;
		endcase
	endfunction
	function automatic logic [31:0] time_word(input rtc_state_t x);
		time_word = {9'h0, x.pm, x.hr, 1'b0, x.mn, 1'b0, x.sc};
	endfunction
	function automatic logic [31:0] date_word(input rtc_state_t x);
		date_word = {8'h0, x.yr, x.wd, x.mo, 2'b0, x.dt};
	endfunction
	function automatic logic alarm_hit(input logic [31:0] a, input logic [31:0] tw,
		input logic [5:0] dt);
		alarm_hit = (a[AL_MSK_SEC] || a[6:0] == tw[6:0])
			&& (a[AL_MSK_MIN] || a[14:8] == tw[14:8])
			&& (a[AL_MSK_HR] || a[22:16] == tw[22:16])
			&& (a[AL_MSK_DT] || a[29:24] == dt);
	endfunction
	always_comb begin
		s_next = s_reg;
		ev = '0;
		clr = '0;
		tev = '0;
		rmux = '0;
		day_roll = 1'b0;
		pre_sec = 1'b0;
		ref_sec = 1'b0;
		dec = '0;
		// Fast clock divided by 32
		if (high_speed_external_clock && !s_reg.fast_p)
			s_next.hdiv = s_reg.hdiv + 5'h1;
		s_next.fast_p = high_speed_external_clock;
		case (rtc_src_t'(s_reg.ctrl[C_SEL+:2])) // RULE12
			SRC_XTAL: lvl = clk_xtal;
			SRC_OSC: lvl = clk_osc;
			SRC_LSI: lvl = clk_lsi;
			SRC_FAST32: lvl = s_reg.hdiv[HDIV_MSB];
			default: lvl = clk_xtal;
		endcase
		s_next.src_p = lvl;
		tick = lvl && !s_reg.src_p;
		if (tick)
			s_next.win = s_reg.win + 20'h1;
		// Drop calm pulses, add one every 2^11 pulses, per 2^20 window
		cal_tick = tick && (s_reg.win >= {11'h0, s_reg.calm}); // RULE8
		extra = tick && s_reg.calp && (s_reg.win[CALP_BITS-1:0] == '0); // RULE8
		if (cal_tick && s_reg.shcnt != '0)
			s_next.shcnt = s_reg.shcnt - 15'h1; // RULE7
		else
			dec = {1'b0, cal_tick} + {1'b0, extra};
		if (dec != '0) begin
			if ({13'h0, dec} > s_reg.ss) begin
				s_next.ss = s_reg.presc + s_reg.ss + 15'h1 - {13'h0, dec};
				pre_sec = 1'b1;
			end else
				s_next.ss = s_reg.ss - {13'h0, dec};
		end
		s_next.ref_p = ref_clk_in;
		if (s_reg.ctrl[C_REFON] && ref_clk_in && !s_reg.ref_p) begin // RULE5
			if (s_reg.refcnt == (s_reg.ctrl[C_REF60] ? REF60_LAST : REF50_LAST)) begin
				s_next.refcnt = '0;
				ref_sec = 1'b1;
				s_next.ss = s_reg.presc;
			end else
				s_next.refcnt = s_reg.refcnt + 6'h1;
		end
		add1s = wr && addr == OFS_SHIFT && wdata[SH_ADD1S]; // RULE7
		sec_step = (s_reg.ctrl[C_REFON] ? ref_sec : pre_sec) || add1s;
		if (sec_step) begin // RULE3
			s_next.sc = 7'(bcd_inc({1'b0, s_reg.sc}));
			if (s_reg.sc == SEC_LAST) begin
				s_next.sc = '0;
				s_next.mn = 7'(bcd_inc({1'b0, s_reg.mn}));
				if (s_reg.mn == MIN_LAST) begin
					s_next.mn = '0;
					s_next.hr = 6'(bcd_inc({2'b0, s_reg.hr}));
					if (s_reg.ctrl[C_FMT12]) begin
						if (s_reg.hr == HR_ELEVEN) begin
							s_next.pm = !s_reg.pm;
							day_roll = s_reg.pm;
						end else if (s_reg.hr == HR_TWELVE)
							s_next.hr = HR_ONE;
					end else if (s_reg.hr == HR_LAST24) begin
						s_next.hr = '0;
						day_roll = 1'b1;
					end
				end
			end
		end
		if (day_roll) begin // RULE4
			s_next.wd = (s_reg.wd == WD_LAST) ? WD_FIRST : s_reg.wd + 3'h1;
			s_next.dt = 6'(bcd_inc({2'b0, s_reg.dt}));
			if (s_reg.dt == month_last(s_reg.mo, s_reg.yr)) begin
				s_next.dt = DAY_ONE;
				s_next.mo = 5'(bcd_inc({3'b0, s_reg.mo}));
				if (s_reg.mo == MON_DEC) begin
					s_next.mo = MON_JAN;
					s_next.yr = (s_reg.yr == YR_LAST) ? '0 : bcd_inc(s_reg.yr);
				end
			end
		end
		if (sec_step) begin // RULE6
			ev[S_ALRA] = alarm_hit(s_reg.alra, time_word(s_next), s_next.dt);
			ev[S_ALRB] = alarm_hit(s_reg.alrb, time_word(s_next), s_next.dt);
		end
		if (!s_reg.ctrl[C_WUTEN])
			s_next.wucnt = s_reg.wut;
		else if (sec_step) begin // RULE11
			if (s_reg.wucnt == '0) begin
				s_next.wucnt = s_reg.wut;
				ev[S_WUT] = 1'b1;
			end else
				s_next.wucnt = s_reg.wucnt - 17'h1;
		end
		// Tamper level must persist for 1, 2, 4 or 8 source pulses
		tin = {tamper_input_three, tamper_input_two, tamper_input_one};
		need = 4'h1 << s_reg.ctrl[C_FILT+:2];
		for (int i = 0; i < NUM_TAMP; i++) begin // RULE9
			if (!tin[i])
				s_next.tcnt[i] = '0;
			else if (tick && s_reg.tcnt[i] != need) begin
				s_next.tcnt[i] = s_reg.tcnt[i] + 4'h1;
				tev[i] = (s_reg.tcnt[i] + 4'h1) == need;
			end
		end
		ev[S_TAMP+:NUM_TAMP] = tev;
		s_next.ts_p = timestamp_input;
		ts_edge = timestamp_input && !s_reg.ts_p;
		ev[S_TS] = ts_edge;
		if (ts_edge || (s_reg.ctrl[C_TAMPTS] && tev != '0)) begin // RULE10
			s_next.tst = time_word(s_reg);
			s_next.tsd = date_word(s_reg);
			s_next.tss = s_reg.ss;
		end
		if (wr) begin
			case (addr)
				OFS_TIME: begin
					s_next.pm = wdata[22];
					s_next.hr = wdata[21:16];
					s_next.mn = wdata[14:8];
					s_next.sc = wdata[6:0];
					s_next.ss = s_reg.presc;
				end
				OFS_DATE: begin
					s_next.yr = wdata[23:16];
					s_next.wd = wdata[15:13];
					s_next.mo = wdata[12:8];
					s_next.dt = wdata[5:0];
				end
				OFS_CTRL: s_next.ctrl = wdata[CTRL_W-1:0];
				OFS_PRESC: s_next.presc = wdata[14:0];
				OFS_WUT: s_next.wut = wdata[16:0];
				OFS_CALIB: begin
					s_next.calm = wdata[8:0];
					s_next.calp = wdata[CAL_PLUS];
				end
				OFS_SHIFT: s_next.shcnt = wdata[14:0]; // RULE7
				OFS_ALRA: s_next.alra = wdata;
				OFS_ALRB: s_next.alrb = wdata;
				OFS_ICLR: clr = wdata[STS_W-1:0];
				OFS_IEN: s_next.ien = wdata[STS_W-1:0];
				default: begin
					if (addr[7:6] == OFS_BKP[7:6])
						s_next.bkp[addr[5:2]] = wdata; // RULE1
				end
			endcase
		end
		// Event set wins over a same-cycle clear
		s_next.sts = (s_reg.sts & ~clr) | ev; // RULE13
		s_next.irq = |(s_next.sts & s_next.ien); // RULE13
		if (rd) begin
			case (addr)
				OFS_TIME: rmux = time_word(s_reg);
				OFS_DATE: rmux = date_word(s_reg);
				OFS_CTRL: rmux = 32'(s_reg.ctrl);
				OFS_SUBSEC: rmux = 32'(s_reg.ss);
				OFS_PRESC: rmux = 32'(s_reg.presc);
				OFS_WUT: rmux = 32'(s_reg.wut);
				OFS_CALIB: rmux = {16'h0, s_reg.calp, 6'h0, s_reg.calm};
				OFS_SHIFT: rmux = 32'(s_reg.shcnt);
				OFS_ALRA: rmux = s_reg.alra;
				OFS_ALRB: rmux = s_reg.alrb;
				OFS_TSTIME: rmux = s_reg.tst;
				OFS_TSDATE: rmux = s_reg.tsd;
				OFS_TSSS: rmux = 32'(s_reg.tss);
				OFS_ISTS: rmux = 32'(s_reg.sts);
				OFS_IEN: rmux = 32'(s_reg.ien);
				default: begin
					if (addr[7:6] == OFS_BKP[7:6])
						rmux = s_reg.bkp[addr[5:2]];
				end
			endcase
		end
		s_next.rdata = rmux;
		if (reset) begin
			s_next = '0;
			s_next.bkp = s_reg.bkp; // RULE2
			s_next.presc = PRESC_RST;
			s_next.ss = PRESC_RST;
			s_next.wut = WUT_RST;
			s_next.wucnt = WUT_RST;
			s_next.wd = WD_RST;
			s_next.mo = MON_JAN;
			s_next.dt = DAY_ONE;
		end
	end
	always_ff @(posedge mclk) begin
		s_reg <= s_next;
	end
	assign rdata = s_reg.rdata;
	assign irq = s_reg.irq;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// Words are unknown at power-up, so compare old and new as a whole
	property p_bkp_keep;
		disable iff (1'b0) reset |=> $stable(s_reg.bkp);
	endproperty
	a_bkp_keep: assert property (p_bkp_keep) else $error("Backup lost on reset"); // RULE2
	property p_bkp_wr;
		wr && addr[7:6] == OFS_BKP[7:6] |=> s_reg.bkp[$past(addr[5:2])] == $past(wdata);
	endproperty
	a_bkp_wr: assert property (p_bkp_wr) else $error("Backup write lost"); // RULE1
	property p_sec_wrap;
		sec_step && s_reg.sc == SEC_LAST && !wr |=> s_reg.sc == '0 ##0 $changed(s_reg.mn);
	endproperty
	a_sec_wrap: assert property (p_sec_wrap) else $error("Seconds wrap wrong"); // RULE3
	property p_hr12;
		sec_step && s_reg.ctrl[C_FMT12] && s_reg.sc == SEC_LAST && s_reg.mn == MIN_LAST
			&& s_reg.hr == HR_ELEVEN && !wr |=> s_reg.hr == HR_TWELVE && $changed(s_reg.pm);
	endproperty
	a_hr12: assert property (p_hr12) else $error("12 hour rollover wrong"); // RULE3
	property p_month_end;
		day_roll && s_reg.dt == month_last(s_reg.mo, s_reg.yr) && !wr
			|=> s_reg.dt == DAY_ONE ##1 s_reg.dt == DAY_ONE || !$stable(s_reg.dt);
	endproperty
	a_month_end: assert property (p_month_end) else $error("Month end wrong"); // RULE4
	property p_alarm;
		ev[S_ALRA] && s_reg.ien[S_ALRA] |=> s_reg.sts[S_ALRA] && s_reg.irq;
	endproperty
	a_alarm: assert property (p_alarm) else $error("Alarm not flagged"); // RULE6
	property p_wut;
		s_reg.ctrl[C_WUTEN] && sec_step && s_reg.wucnt == '0
			|=> s_reg.sts[S_WUT] && s_reg.wucnt == $past(s_reg.wut);
	endproperty
	a_wut: assert property (p_wut) else $error("Wakeup reload wrong"); // RULE11
	property p_tstamp;
		ts_edge && !wr |=> s_reg.tst[6:0] == $past(s_reg.sc) && s_reg.sts[S_TS];
	endproperty
	a_tstamp: assert property (p_tstamp) else $error("Timestamp not captured"); // RULE10
	property p_tamper;
		tev[0] |=> s_reg.sts[S_TAMP] ##1 s_reg.sts[S_TAMP] || $past(wr);
	endproperty
	a_tamper: assert property (p_tamper) else $error("Tamper not flagged"); // RULE9
endmodule
`default_nettype wire

// File: tb/rtc_src_model.sv
// Far-side model: RTC clock sources, reference input, tamper and timestamp pins
// Assumes the bench calls its tasks; every line changes just after a rising mclk
`timescale 1ns/100ps
`default_nettype none
module rtc_src_model (
	// System
	input wire logic mclk,
	// Sources: xtal, osc, lsi, fast clock, reference
	output var logic [4:0] src,
	// Pins: tamper one to three, timestamp
	output var logic [3:0] pin
);
	initial begin
		src = 5'h00;
		pin = 4'h0;
	end
	// Sources stand still low between bursts
	task automatic pulse(input int idx, input int n);
		repeat (n) begin
			@(posedge mclk);
			src[idx] <= 1'b1;
			repeat (2) @(posedge mclk);
			src[idx] <= 1'b0;
			repeat (2) @(posedge mclk);
		end
	endtask
	task automatic set_pin(input int idx, input logic v);
		@(posedge mclk);
		pin[idx] <= v;
		repeat (3) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

// File: tb/test_bcd_calendar_rtc_with_backup.sv
// Bench for the RTC core: register table, calendar, events, backup words
// Assumes rtc_top and rtc_src_model; one 250 MHz clock
`timescale 1ns/100ps
`default_nettype none
module test_bcd_calendar_rtc_with_backup;
	import rtc_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic we;
		logic [31:0] e;
	} rtc_row_t;
	logic mclk, reset, wr, rd, irq;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [4:0] src;
	logic [3:0] pin;
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	rtc_row_t rows[15];
	logic [31:0] tc[12];
	logic [31:0] dc[12];
	rtc_top uut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .clk_xtal(src[0]), .clk_osc(src[1]), .clk_lsi(src[2]),
		.high_speed_external_clock(src[3]), .ref_clk_in(src[4]),
		.tamper_input_one(pin[0]), .tamper_input_two(pin[1]),
		.tamper_input_three(pin[2]), .timestamp_input(pin[3]), .irq(irq));
	rtc_src_model u_src (.mclk(mclk), .src(src), .pin(pin));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total = err_total + 1;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic tick(input int n);
		u_src.pulse(0, n);
	endtask
	function automatic logic [31:0] dt(logic [7:0] y, logic [2:0] w, logic [4:0] m,
		logic [5:0] d);
		return {8'h00, y, w, m, 2'b00, d};
	endfunction
	initial begin
		reset = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		rows = '{'{8'h00, 32'h0, 1'b0, 32'h0}, '{8'h04, 32'h0, 1'b0, 32'hc101},
			'{8'h08, 32'h0, 1'b0, 32'h0}, '{8'h0c, 32'h0, 1'b0, 32'h7fff},
			'{8'h10, 32'h0, 1'b0, 32'h7fff}, '{8'h14, 32'h0, 1'b0, 32'h1ffff},
			'{8'h34, 32'h0, 1'b0, 32'h0}, '{8'h3c, 32'h0, 1'b0, 32'h0},
			'{8'h38, 32'h0, 1'b0, 32'h0}, '{8'h80, 32'h0, 1'b0, 32'h0},
			'{8'h40, 32'ha5a50001, 1'b1, 32'ha5a50001},
			'{8'h7c, 32'h5a5affff, 1'b1, 32'h5a5affff},
			'{8'h34, 32'h7f, 1'b1, 32'h0}, '{8'h80, 32'h1234, 1'b1, 32'h0},
			'{8'h3c, 32'h7f, 1'b1, 32'h7f}};
		tc = '{32'h0, 32'h235959, 32'h0, 32'h1, 32'h115959, 32'h520000,
			32'h1, 32'h515959, 32'h120000, 32'h1, 32'h125959, 32'h010000};
		dc = '{dt(8'h01, 3'h1, 5'h02, 6'h28), dt(8'h01, 3'h2, 5'h03, 6'h01),
			dt(8'h04, 3'h1, 5'h02, 6'h28), dt(8'h04, 3'h2, 5'h02, 6'h29),
			dt(8'h04, 3'h2, 5'h02, 6'h29), dt(8'h04, 3'h3, 5'h03, 6'h01),
			dt(8'h04, 3'h7, 5'h04, 6'h30), dt(8'h04, 3'h1, 5'h05, 6'h01),
			dt(8'h04, 3'h3, 5'h01, 6'h31), dt(8'h04, 3'h4, 5'h02, 6'h01),
			dt(8'h99, 3'h4, 5'h12, 6'h31), dt(8'h00, 3'h5, 5'h01, 6'h01)};
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].we)
				wreg(rows[i].a, rows[i].d);
			rchk(rows[i].a, rows[i].e);
		end
		$display("register table done");
		wreg(OFS_PRESC, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wreg(OFS_CTRL, tc[3*i]);
			wreg(OFS_TIME, tc[3*i+1]);
			tick(1);
			rchk(OFS_TIME, tc[3*i+2]);
		end
		wreg(OFS_CTRL, 32'h0);
		for (int i = 0; i < 6; i++) begin
			wreg(OFS_TIME, 32'h235959);
			wreg(OFS_DATE, dc[2*i]);
			tick(1);
			rchk(OFS_DATE, dc[2*i+1]);
		end
		$display("calendar done");
		for (int s = 0; s < 4; s++) begin
			wreg(OFS_CTRL, 32'(s) << C_SEL);
			wreg(OFS_TIME, 32'h0);
			u_src.pulse((s + 1) % 4, 1);
			u_src.pulse(s, s == 3 ? 32 : 1);
			rchk(OFS_TIME, 32'h1);
		end
		for (int f = 0; f < 2; f++) begin
			wreg(OFS_CTRL, f ? 32'h6 : 32'h2);
			wreg(OFS_TIME, 32'h0);
			u_src.pulse(4, f ? 59 : 49);
			rchk(OFS_TIME, 32'h0);
			u_src.pulse(4, 1);
			rchk(OFS_TIME, 32'h1);
		end
		$display("sources done");
		wreg(OFS_CTRL, 32'h0);
		wreg(OFS_TIME, 32'h0);
		wreg(OFS_SHIFT, 32'h2);
		rchk(OFS_SHIFT, 32'h2);
		tick(2);
		rchk(OFS_TIME, 32'h0);
		tick(1);
		rchk(OFS_TIME, 32'h1);
		wreg(OFS_SHIFT, 32'h80000000);
		rchk(OFS_TIME, 32'h2);
		$display("shift done");
		wreg(OFS_ICLR, 32'h7f);
		wreg(OFS_IEN, 32'h1);
		wreg(OFS_ALRA, 32'h80808005);
		wreg(OFS_ALRB, 32'h80808006);
		wreg(OFS_TIME, 32'h4);
		tick(1);
		rchk(OFS_ISTS, 32'h1);
		chk_bit(irq, 1'b1);
		tick(1);
		wreg(OFS_ICLR, 32'h1);
		rchk(OFS_ISTS, 32'h2);
		chk_bit(irq, 1'b0);
		wreg(OFS_IEN, 32'h2);
		rchk(OFS_IEN, 32'h2);
		chk_bit(irq, 1'b1);
		$display("alarms done");
		wreg(OFS_ICLR, 32'h7f);
		wreg(OFS_IEN, 32'h4);
		wreg(OFS_WUT, 32'h1);
		wreg(OFS_CTRL, 32'h8);
		tick(2);
		rchk(OFS_ISTS, 32'h4);
		wreg(OFS_ICLR, 32'h4);
		tick(2);
		rchk(OFS_ISTS, 32'h4);
		chk_bit(irq, 1'b1);
		$display("wakeup done");
		wreg(OFS_CTRL, 32'h0);
		wreg(OFS_ICLR, 32'h7f);
		wreg(OFS_IEN, 32'h78);
		wreg(OFS_TIME, 32'h123456);
		u_src.set_pin(3, 1'b1);
		rchk(OFS_ISTS, 32'h8);
		rchk(OFS_TSTIME, 32'h123456);
		rchk(OFS_TSDATE, dt(8'h00, 3'h5, 5'h01, 6'h01));
		chk_bit(irq, 1'b1);
		u_src.set_pin(3, 1'b0);
		// Slow second keeps the calendar still while the filter counts
		wreg(OFS_PRESC, 32'h3);
		wreg(OFS_CTRL, 32'h90);
		for (int i = 0; i < 3; i++) begin
			wreg(OFS_ICLR, 32'h7f);
			wreg(OFS_TIME, 32'h10 + 32'(i));
			u_src.set_pin(i, 1'b1);
			tick(1);
			rchk(OFS_ISTS, 32'h0);
			tick(1);
			rchk(OFS_ISTS, 32'h10 << i);
			rchk(OFS_TSTIME, 32'h10 + 32'(i));
			u_src.set_pin(i, 1'b0);
		end
		$display("tamper and timestamp done");
		reset <= 1'b1;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		#1 chk_bit(irq, 1'b0);
		rchk(OFS_ISTS, 32'h0);
		rchk(OFS_BKP, 32'ha5a50001);
		rchk(OFS_BKP + 8'h3c, 32'h5a5affff);
		rchk(OFS_TIME, 32'h0);
		$display("reset done");
		// Window count is zero after reset: first pulse gets the added one
		wreg(OFS_PRESC, 32'h1);
		wreg(OFS_CALIB, 32'h8000);
		wreg(OFS_TIME, 32'h0);
		rchk(OFS_CALIB, 32'h8000);
		tick(1);
		rchk(OFS_TIME, 32'h1);
		// Window count one: next pulse dropped, the one after counted
		wreg(OFS_CALIB, 32'h2);
		tick(2);
		rchk(OFS_TIME, 32'h1);
		$display("calibration done");
		stop_test();
	end
endmodule
`default_nettype wire
